// *** design/bmre_map.vh ***
// constants of the boot mode and reset entry block
// included by bare name; definitions only
`ifndef BMRE_MAP_VH
`define BMRE_MAP_VH

// decoded boot source codes
`define BMRE_MODE_W        2
`define BMRE_MODE_NONE     2'h0
`define BMRE_MODE_HOST     2'h1
`define BMRE_MODE_EPROM    2'h2
`define BMRE_MODE_BAD      2'h3

// sequencer state codes
`define BMRE_ST_W          2
`define BMRE_ST_RESET      2'h0
`define BMRE_ST_BOOT       2'h1
`define BMRE_ST_RUN        2'h2
`define BMRE_ST_HALT       2'h3

// program address width and hardware reset vector
`define BMRE_ADDR_W        24
`define BMRE_RESET_VECTOR  24'h020004

// time that the boot memory select stays asserted for an eprom load
`define BMRE_LOAD_TIME_NS  1024
`define BMRE_CLK_PERIOD_NS 4
`define BMRE_LOAD_CYCLES   ((`BMRE_LOAD_TIME_NS + `BMRE_CLK_PERIOD_NS - 1) / `BMRE_CLK_PERIOD_NS)
`define BMRE_CNT_W         16

// depth of the reset synchroniser
`define BMRE_SYNC_STAGES   2

`endif

// *** design/bmre_rst_sync.v ***
// reset synchroniser: asynchronous assertion, clocked release
// assumes clk_sys free running; rst and arst_n may change at any time
`timescale 1ns/1ps
`default_nettype none

module bmre_rst_sync #(
	parameter STAGES = 2
) (
	// clock and reset
	input  wire clk_sys,
	input  wire rst,
	// asynchronous active-low reset in
	input  wire arst_n,
	// synchronised active-high reset out
	output wire srst
);

	reg [STAGES-1:0] chain_r;

	// any assertion clears the chain at once; release ripples through
	always @(posedge clk_sys or posedge rst or negedge arst_n) begin
		if (rst) begin
			chain_r <= {STAGES{1'b0}};
		end else if (!arst_n) begin
			chain_r <= {STAGES{1'b0}};
		end else begin
			chain_r <= {chain_r[STAGES-2:0], 1'b1};
		end
	end

	assign srst = ~chain_r[STAGES-1];

endmodule

`default_nettype wire

// *** design/bmre_boot_entry.v ***
// boot mode decode and reset entry sequencer
// assumes straps are hardwired and synchronous to clk_sys; proc_reset_n is asynchronous
//
// Behaviour
// RULE1 - eprom select high boots from eprom; else link strap and memory select decide; with link strap also high the code decodes bad instead
// RULE2 - eprom select 1, link strap 0: eprom boot, drive memory select as chip select
// RULE3 - eprom select 0, link strap 0, memory select high: boot from host processor
// RULE4 - all three straps low: no boot, fetch from external memory
// RULE5 - one instruction cycle per input clock period, no multiplication or division
// RULE6 - the clock source keeps the clock free running at a fixed legal rate
// RULE7 - reset returns a defined state; release starts execution at the reset vector
// RULE8 - the system holds the active-low reset asserted during power-up
// RULE9 - the reset input is asynchronous and synchronised before clocked logic uses it
// RULE10 - straps sampled during reset; decoded source held fixed until next reset
`timescale 1ns/1ps
`default_nettype none
`include "bmre_map.vh"

module bmre_boot_entry #(
	parameter ADDR_W       = `BMRE_ADDR_W,
	parameter RESET_VECTOR = `BMRE_RESET_VECTOR,
	parameter LOAD_CYCLES  = `BMRE_LOAD_CYCLES
) (
	// clock and system reset
	input  wire              clk_sys,
	input  wire              rst,
	// processor reset pin, asynchronous, active low
	input  wire              proc_reset_n,
	// boot configuration straps
	input  wire              eprom_boot_select,
	input  wire              link_boot_strap,
	input  wire              boot_memory_select_in,
	output reg               boot_memory_select_out,
	output reg               boot_memory_select_oe,
	// host boot completion
	input  wire              host_boot_done,
	// boot status
	output reg  [1:0]        boot_mode,
	output reg               boot_active,
	output reg               boot_error,
	// execution
	output reg               core_run,
	output reg               instr_step,
	output reg               fetch_external,
	output reg  [ADDR_W-1:0] fetch_addr
);

	localparam integer           LOAD_LAST = LOAD_CYCLES - 1;
	localparam [`BMRE_CNT_W-1:0] LOAD_CNT  = LOAD_LAST[`BMRE_CNT_W-1:0];

	// synchronised processor reset
	wire                   core_rst;

	// sequencer
	reg  [`BMRE_ST_W-1:0]  state_r;
	reg  [`BMRE_ST_W-1:0]  state_nxt;
	reg  [1:0]             mode_r;
	reg  [1:0]             mode_nxt;
	reg  [`BMRE_CNT_W-1:0] cnt_r;
	reg  [`BMRE_CNT_W-1:0] cnt_nxt;

	// decoded flags
	wire                   mode_eprom;
	wire                   mode_none;
	wire                   mode_bad;
	wire                   enter_boot;
	wire                   enter_run;
	wire                   in_run;

	// output next values
	reg  [1:0]             boot_mode_nxt;
	reg                    boot_active_nxt;
	reg                    boot_error_nxt;
	reg                    bms_out_nxt;
	reg                    bms_oe_nxt;
	reg                    core_run_nxt;
	reg                    instr_step_nxt;
	reg                    fetch_external_nxt;
	reg  [ADDR_W-1:0]      fetch_addr_nxt;

	// straps to boot source
	function [1:0] decode_mode;
		input eb;
		input lb;
		input bm;
		begin
			if (eb && !lb) begin
				decode_mode = `BMRE_MODE_EPROM; // RULE1 RULE2
			end else if (eb || lb) begin
				decode_mode = `BMRE_MODE_BAD;
			end else if (bm) begin
				decode_mode = `BMRE_MODE_HOST; // RULE3
			end else begin
				decode_mode = `BMRE_MODE_NONE; // RULE4
			end
		end
	endfunction

	// pin reset enters clocked logic only through the synchroniser
	bmre_rst_sync #(
		.STAGES (`BMRE_SYNC_STAGES)
	) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.arst_n  (proc_reset_n),
		.srst    (core_rst)
	); // RULE9

	// sequencer next state
	always @* begin
		state_nxt = state_r;
		case (state_r)
			`BMRE_ST_RESET: begin
				if (!core_rst) begin
					if (mode_r == `BMRE_MODE_NONE) begin
						state_nxt = `BMRE_ST_RUN; // RULE4
					end else if (mode_r == `BMRE_MODE_BAD) begin
						state_nxt = `BMRE_ST_HALT;
					end else begin
						state_nxt = `BMRE_ST_BOOT;
					end
				end
			end
			`BMRE_ST_BOOT: begin
				if (mode_r == `BMRE_MODE_EPROM && cnt_r == LOAD_CNT) begin
					state_nxt = `BMRE_ST_RUN;
				end else if (mode_r == `BMRE_MODE_HOST && host_boot_done) begin
					state_nxt = `BMRE_ST_RUN;
				end
			end
			`BMRE_ST_RUN: begin
				state_nxt = `BMRE_ST_RUN;
			end
			`BMRE_ST_HALT: begin
				state_nxt = `BMRE_ST_HALT;
			end
			default: begin
				state_nxt = `BMRE_ST_RESET;
			end
		endcase
		if (core_rst) begin
			state_nxt = `BMRE_ST_RESET; // RULE7
		end
	end

	// flags shared by the next-value logic
	assign mode_eprom = (mode_r == `BMRE_MODE_EPROM);
	assign mode_none  = (mode_r == `BMRE_MODE_NONE);
	assign mode_bad   = (mode_r == `BMRE_MODE_BAD);
	assign enter_boot = (state_nxt == `BMRE_ST_BOOT);
	assign enter_run  = (state_nxt == `BMRE_ST_RUN);
	assign in_run     = (state_r == `BMRE_ST_RUN);

	// straps follow the pins only while reset holds; frozen after
	always @* begin
		mode_nxt = mode_r;
		if (core_rst) begin
			mode_nxt = decode_mode(eprom_boot_select, link_boot_strap,
				boot_memory_select_in); // RULE10
		end
	end

	// load counter runs only while the sequencer stays in boot
	always @* begin
		if (enter_boot && state_r == `BMRE_ST_BOOT) begin
			cnt_nxt = cnt_r + 1'b1;
		end else begin
			cnt_nxt = {`BMRE_CNT_W{1'b0}};
		end
	end

	// output next values; every output leaves through a flop
	always @* begin
		boot_mode_nxt      = core_rst ? `BMRE_MODE_NONE : mode_r; // RULE10
		boot_error_nxt     = !core_rst && mode_bad;
		boot_active_nxt    = enter_boot;
		// chip select driven only in eprom mode, low while loading
		bms_oe_nxt         = !core_rst && mode_eprom; // RULE2
		bms_out_nxt        = !(enter_boot && mode_eprom); // RULE2
		fetch_external_nxt = enter_run && mode_none; // RULE4
		core_run_nxt       = enter_run;
		// one instruction per clock; start at the reset vector
		instr_step_nxt     = enter_run; // RULE5
		if (!in_run) begin
			fetch_addr_nxt = RESET_VECTOR[ADDR_W-1:0]; // RULE7
		end else begin
			fetch_addr_nxt = fetch_addr + 1'b1; // RULE5
		end
	end

	// register stage
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r                <= `BMRE_ST_RESET;
			mode_r                 <= `BMRE_MODE_NONE;
			cnt_r                  <= {`BMRE_CNT_W{1'b0}};
			boot_memory_select_out <= 1'b1;
			boot_memory_select_oe  <= 1'b0;
			boot_mode              <= `BMRE_MODE_NONE;
			boot_active            <= 1'b0;
			boot_error             <= 1'b0;
			core_run               <= 1'b0;
			instr_step             <= 1'b0;
			fetch_external         <= 1'b0;
			fetch_addr             <= RESET_VECTOR[ADDR_W-1:0];
		end else begin
			state_r                <= state_nxt;
			mode_r                 <= mode_nxt;
			cnt_r                  <= cnt_nxt;
			boot_memory_select_out <= bms_out_nxt;
			boot_memory_select_oe  <= bms_oe_nxt;
			boot_mode              <= boot_mode_nxt;
			boot_active            <= boot_active_nxt;
			boot_error             <= boot_error_nxt;
			core_run               <= core_run_nxt;
			instr_step             <= instr_step_nxt;
			fetch_external         <= fetch_external_nxt;
			fetch_addr             <= fetch_addr_nxt;
		end
	end

endmodule

`default_nettype wire

// *** dv/bmre_board.sv ***
// board model: resolves the boot memory select pin
// assumes the strap level stands whenever the device does not drive
`timescale 1ns/1ps
`default_nettype none
module bmre_board (
	// pin parties
	input  wire logic oe,
	input  wire logic drv,
	input  wire logic strap,
	output wire logic pin
);
	assign pin = oe ? drv : strap;
endmodule
`default_nettype wire

// *** dv/bmre_checker.sv ***
// checker on the boot entry block ports
// assumes binding to bmre_boot_entry
`timescale 1ns/1ps
`default_nettype none
module bmre_checker #(
	parameter ADDR_W       = 24,
	parameter RESET_VECTOR = 24'h020004
) (
	// clock and resets
	input wire logic              clk_sys,
	input wire logic              rst,
	input wire logic              proc_reset_n,
	// watched outputs
	input wire logic              boot_memory_select_out,
	input wire logic              boot_memory_select_oe,
	input wire logic [1:0]        boot_mode,
	input wire logic              boot_active,
	input wire logic              boot_error,
	input wire logic              core_run,
	input wire logic              instr_step,
	input wire logic              fetch_external,
	input wire logic [ADDR_W-1:0] fetch_addr
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst || !proc_reset_n);
	property p_oe; boot_memory_select_oe |-> boot_mode == 2'h2; endproperty
	a_oe: assert property (p_oe) else $error("oe");
	property p_cs; boot_active && boot_mode == 2'h2 |-> !boot_memory_select_out; endproperty
	a_cs: assert property (p_cs) else $error("cs");
	property p_host; boot_mode == 2'h1 |-> !boot_memory_select_oe; endproperty
	a_host: assert property (p_host) else $error("host");
	property p_ext; fetch_external |-> core_run && boot_mode == 2'h0; endproperty
	a_ext: assert property (p_ext) else $error("ext");
	property p_step; core_run ##1 core_run |-> instr_step && fetch_addr == $past(fetch_addr) + 1'b1; endproperty
	a_step: assert property (p_step) else $error("step");
	property p_vec; $rose(core_run) |-> fetch_addr == RESET_VECTOR; endproperty
	a_vec: assert property (p_vec) else $error("vec");
	property p_rel; $rose(proc_reset_n) |-> !(boot_active || core_run) [*3]; endproperty
	a_rel: assert property (p_rel) else $error("rel");
	property p_hold; core_run |=> $stable(boot_mode); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_err; boot_error |-> boot_mode == 2'h3 && !core_run; endproperty
	a_err: assert property (p_err) else $error("err");
endmodule
bind bmre_boot_entry bmre_checker #(
	.ADDR_W       (ADDR_W),
	.RESET_VECTOR (RESET_VECTOR)
) chk (
	.clk_sys                (clk_sys),
	.rst                    (rst),
	.proc_reset_n           (proc_reset_n),
	.boot_memory_select_out (boot_memory_select_out),
	.boot_memory_select_oe  (boot_memory_select_oe),
	.boot_mode              (boot_mode),
	.boot_active            (boot_active),
	.boot_error             (boot_error),
	.core_run               (core_run),
	.instr_step             (instr_step),
	.fetch_external         (fetch_external),
	.fetch_addr             (fetch_addr)
);
`default_nettype wire

// *** dv/testbench.sv ***
// testbench for the boot entry block
// assumes the board model resolves the memory select pin
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, v) begin cmp_count++; if ((v) !== (e)) begin mismatches++; \
	$display("[ERR] %s exp %h got %h", n, e, v); end end
module testbench;
	logic clk_sys = 0, rst = 1, prn = 0, eb = 0, lb = 0, bm = 0, hd = 0;
	wire pin, oe, out, err, act, run, stp, ext;
	wire [1:0] md;
	wire [23:0] fa;
	int mismatches = 0, cmp_count = 0, cyc = 0;
	initial forever #2 clk_sys = ~clk_sys;
	bmre_board brd (.oe(oe), .drv(out), .strap(bm), .pin(pin));
	bmre_boot_entry #(.LOAD_CYCLES(4)) dut (.clk_sys(clk_sys), .rst(rst), .proc_reset_n(prn),
		.eprom_boot_select(eb), .link_boot_strap(lb), .boot_memory_select_in(pin),
		.boot_memory_select_out(out), .boot_memory_select_oe(oe), .host_boot_done(hd),
		.boot_mode(md), .boot_active(act), .boot_error(err), .core_run(run),
		.instr_step(stp), .fetch_external(ext), .fetch_addr(fa));
	task end_sim;
		if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			end_sim;
		end
	end
	task automatic boot(input logic e, input logic l, input logic b);
		@(posedge clk_sys);
		prn <= 0;
		{eb, lb, bm} <= {e, l, b};
		hd <= 0;
		@(posedge clk_sys);
		#1 `CHK("run_rst", 1'b0, run)
		@(posedge clk_sys);
		prn <= 1;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	task automatic wait_run;
		repeat (20) if (run !== 1'b1) begin
			@(posedge clk_sys);
			#1;
		end
		`CHK("vec", 24'h020004, fa)
		`CHK("step", 1'b1, stp)
		@(posedge clk_sys);
		#1 `CHK("next", 24'h020005, fa)
	endtask
	task automatic t_eprom;
		boot(1, 0, 1);
		`CHK("mode", 2'h2, md)
		`CHK("cs", 1'b0, pin)
		`CHK("cs_oe", 1'b1, oe)
		`CHK("busy", 1'b1, act)
		repeat (3) @(posedge clk_sys);
		#1 `CHK("load", 1'b0, pin)
		@(posedge clk_sys);
		#1 `CHK("load_end", 1'b1, run)
		wait_run;
		`CHK("cs_off", 1'b1, pin)
	endtask
	task automatic t_host;
		boot(0, 0, 1);
		`CHK("mode", 2'h1, md)
		`CHK("host_oe", 1'b0, oe)
		`CHK("host_busy", 1'b1, act)
		repeat (5) @(posedge clk_sys);
		#1 `CHK("wait", 1'b0, run)
		@(posedge clk_sys);
		hd <= 1;
		eb <= 1;
		#1 wait_run;
		`CHK("hold", 2'h1, md)
		`CHK("no_ext", 1'b0, ext)
	endtask
	task automatic t_none;
		boot(0, 0, 0);
		`CHK("ext", 1'b1, ext)
		wait_run;
	endtask
	task automatic t_bad;
		boot(0, 1, 0);
		`CHK("err", 1'b1, err)
		`CHK("bad", 2'h3, md)
		repeat (3) @(posedge clk_sys);
		#1 `CHK("halt", 1'b0, run)
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 0;
		t_eprom;
		t_host;
		t_none;
		t_bad;
		end_sim;
	end
endmodule
`default_nettype wire
